// *** hw/serial_cmd_pkg.sv ***
// Constants, types and state records for the serial command decoder.
// Assumes a 40 MHz mclk and a slower host serial clock sampled in mclk.
// Operation
// R1: Command register, 8 bits, write only, starts all.
// R2: Single read or write returns to command wait.
// R3: Reset and power-up land in command wait.
// R4: 32 consecutive ones on data input reset port.
// R5: Command word arrives most significant bit first.
// R6: Gate bit one stalls; zero loads seven bits.
// R7: Host writes zero into command bits 6, 3.
// R8: Bits 5,4 choose write, read, continuous, stop.
// R9: Code 00 writes selected register, then waits.
// R10: Code 01 reads selected register, then waits.
// R11: Code 10 repeats reads of same register.
// R12: Byte 30 hex ends continuous read.
// R13: Data input watched each clock in continuous read; code checks for the stop byte only at byte boundaries.
// R14: Host holds data input low while reading continuously.
// R15: Bits 2..0 select register, bit 2 most significant.
// R16: Select 000: command on write, status on read.
// R17: 1..7: data, mode, filter, none, offset, gain, test.
// R18: Status register reads as eight bits.
// R19: Data register is 16 or 24 bits.
// R20: Unused select moves nothing, changes nothing.
package serial_cmd_pkg;

  localparam int CMD_WIDTH = 8;
  localparam int WORD_MAX = 24;
  localparam int ONES_RESET_COUNT = 32;

  localparam logic [2:0] CMD_REG_OFFSET = 3'h0;
  localparam logic [7:0] CMD_RESET_VALUE = 8'h00;
  localparam logic [7:0] CMD_STOP = 8'h30;
  localparam int KIND_HI_POS = 5;
  localparam int KIND_LO_POS = 4;
  localparam int SEL_MSB_POS = 2;

  localparam logic [1:0] KIND_WRITE = 2'h0;
  localparam logic [1:0] KIND_READ = 2'h1;
  localparam logic [1:0] KIND_CONT = 2'h2;
  localparam logic [1:0] KIND_STOP = 2'h3;

  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_DATA = 3'h1;
  localparam logic [2:0] SEL_MODE = 3'h2;
  localparam logic [2:0] SEL_FILTER = 3'h3;
  localparam logic [2:0] SEL_NONE = 3'h4;
  localparam logic [2:0] SEL_OFFSET = 3'h5;
  localparam logic [2:0] SEL_GAIN = 3'h6;
  localparam logic [2:0] SEL_TEST = 3'h7;

  localparam logic [4:0] LEN_STATUS = 5'h08;
  localparam logic [4:0] LEN_SHORT = 5'h10;
  localparam logic [4:0] LEN_LONG = 5'h18;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_WRITE = 3'h3,
    ST_READ = 3'h2,
    ST_CONT = 3'h6
  } port_state_e;

  typedef struct packed {
    logic [2:0] select;
    logic wr_stb;
    logic [WORD_MAX-1:0] wr_data;
    logic rd_stb;
  } reg_req_s;

  typedef struct packed {
    port_state_e st;
    logic [4:0] bits;
    logic [CMD_WIDTH-1:0] cmd;
    logic [CMD_WIDTH-1:0] window;
    logic [WORD_MAX-1:0] sh;
    logic [5:0] ones;
    logic load;
    logic dout;
    logic soft_rst;
    reg_req_s req;
  } decoder_s;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
    logic sclk_prev;
  } pin_sync_s;

  // Transfer length of each target in serial clocks
  function automatic logic [4:0] word_len(input logic [2:0] sel,
                                          input logic wl24);
    logic [4:0] len;
    len = LEN_LONG;
    case (sel)
      SEL_STATUS: len = LEN_STATUS; // [R18]
      SEL_DATA: len = wl24 ? LEN_LONG : LEN_SHORT; // [R19]
      SEL_MODE: len = LEN_SHORT;
      SEL_FILTER: len = LEN_SHORT;
      default: len = LEN_LONG;
    endcase
    return len;
  endfunction

endpackage

// *** hw/serial_pin_sync.sv ***
// Two-flop synchroniser for serial clock and data pins, with clock edges.
// Assumes both pins are asynchronous to mclk and far slower than it.
`timescale 1ns/1ps
module serial_pin_sync (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sclk_pin,
  input wire logic din_pin,
  output logic sclk_rise,
  output logic sclk_fall,
  output logic din_level
);

  serial_cmd_pkg::pin_sync_s s;
  serial_cmd_pkg::pin_sync_s next_s;

  always_comb begin
    next_s = s;
    next_s.meta = {sclk_pin, din_pin};
    next_s.stable = s.meta;
    next_s.sclk_prev = s.stable[1];
  end

  // Idle level high so a host idling sclk high sees no edge at release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= '{meta: 2'h2, stable: 2'h2, sclk_prev: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign sclk_rise = s.stable[1] & ~s.sclk_prev;
  assign sclk_fall = ~s.stable[1] & s.sclk_prev;
  assign din_level = s.stable[0];

endmodule

// *** hw/serial_cmd_decoder.sv ***
// Serial port command decoder: command word, transfer sequencing, resets.
// Assumes a register bank outside that serves rd_data for reg_req.select
// in the cycle after the select changes and takes reg_req write strobes.
`timescale 1ns/1ps
module serial_cmd_decoder #(
  parameter int ONES_LIMIT = serial_cmd_pkg::ONES_RESET_COUNT
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  input wire logic word_length_24,
  input wire logic [serial_cmd_pkg::WORD_MAX-1:0] rd_data,
  output serial_cmd_pkg::reg_req_s reg_req,
  output logic [serial_cmd_pkg::CMD_WIDTH-1:0] command,
  output serial_cmd_pkg::port_state_e port_state,
  output logic cont_read_active,
  output logic soft_reset
);

  localparam logic [5:0] ONES_TOP = 6'(ONES_LIMIT);

  // Six-bit run counter saturates at the limit
  if (ONES_LIMIT < 8 || ONES_LIMIT > 63) begin : g_limit_check
    $error("ONES_LIMIT must lie in 8..63");
  end

  serial_cmd_pkg::decoder_s s;
  serial_cmd_pkg::decoder_s next_s;
  logic rise;
  logic fall;
  logic din_s;
  logic [4:0] len;
  logic hit;
  logic [serial_cmd_pkg::CMD_WIDTH-1:0] full_cmd;
  logic [serial_cmd_pkg::CMD_WIDTH-1:0] next_window;
  logic [2:0] sel;
  logic [1:0] kind;

  serial_pin_sync u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .sclk_pin(sclk),
    .din_pin(din),
    .sclk_rise(rise),
    .sclk_fall(fall),
    .din_level(din_s)
  );

  assign len = serial_cmd_pkg::word_len(s.req.select, word_length_24);
  assign hit = rise && din_s && (s.ones == ONES_TOP - 6'h01);
  // Gate bit was zero, so bit 7 of the loaded word is zero
  assign full_cmd = {1'b0, s.window[5:0], din_s}; // [R5]
  assign next_window = {s.window[6:0], din_s};
  assign sel = full_cmd[serial_cmd_pkg::SEL_MSB_POS:0]; // [R15]
  assign kind = full_cmd[serial_cmd_pkg::KIND_HI_POS:
                         serial_cmd_pkg::KIND_LO_POS]; // [R8]

  always_comb begin
    next_s = s;
    next_s.req.wr_stb = 1'b0;
    next_s.req.rd_stb = 1'b0;
    next_s.soft_rst = 1'b0;
    next_s.load = 1'b0;
    if (s.load) begin
      // Left-align so the first serial bit is always sh[23]
      next_s.sh = rd_data << (5'(serial_cmd_pkg::WORD_MAX) - len); // [R19]
      next_s.dout = next_s.sh[serial_cmd_pkg::WORD_MAX-1];
      next_s.req.rd_stb = 1'b1;
      next_s.bits = 5'h00;
      next_s.window = 8'h00;
    end
    if (fall && (s.st == serial_cmd_pkg::ST_READ ||
                 s.st == serial_cmd_pkg::ST_CONT)) begin
      next_s.dout = s.sh[serial_cmd_pkg::WORD_MAX-1];
    end
    if (rise) begin
      next_s.ones = din_s ? s.ones + 6'h01 : 6'h00;
      if (s.ones == ONES_TOP) begin
        next_s.ones = din_s ? ONES_TOP : 6'h00;
      end
      case (s.st)
        serial_cmd_pkg::ST_IDLE: begin
          // A one in the gate position keeps us here
          if (!din_s) begin // [R6]
            next_s.st = serial_cmd_pkg::ST_CMD;
            next_s.bits = 5'h00;
            next_s.window = 8'h00;
          end
        end
        serial_cmd_pkg::ST_CMD: begin
          next_s.window = next_window;
          next_s.bits = s.bits + 5'h01;
          if (s.bits == 5'h06) begin
            next_s.cmd = full_cmd; // [R1]
            next_s.st = serial_cmd_pkg::ST_IDLE;
            next_s.bits = 5'h00;
            // Unused select leaves the previous target untouched
            if (sel != serial_cmd_pkg::SEL_NONE) begin // [R20]
              next_s.req.select = sel; // [R16] [R17]
            end
            case (kind)
              serial_cmd_pkg::KIND_WRITE: begin
                // Select 000 write just targets the next command
                if (sel != serial_cmd_pkg::SEL_NONE &&
                    sel != serial_cmd_pkg::SEL_STATUS) begin
                  next_s.st = serial_cmd_pkg::ST_WRITE; // [R9]
                  // Stale read bits must not reach a short write word
                  next_s.sh = '0;
                end
              end
              serial_cmd_pkg::KIND_READ: begin
                if (sel != serial_cmd_pkg::SEL_NONE) begin
                  next_s.st = serial_cmd_pkg::ST_READ; // [R10]
                  next_s.load = 1'b1;
                end
              end
              serial_cmd_pkg::KIND_CONT: begin
                if (sel != serial_cmd_pkg::SEL_NONE) begin
                  next_s.st = serial_cmd_pkg::ST_CONT; // [R11]
                  next_s.load = 1'b1;
                end
              end
              default: begin
                next_s.st = serial_cmd_pkg::ST_IDLE;
              end
            endcase
          end
        end
        serial_cmd_pkg::ST_WRITE: begin
          next_s.sh = {s.sh[22:0], din_s};
          next_s.bits = s.bits + 5'h01;
          if (s.bits == len - 5'h01) begin
            next_s.req.wr_stb = 1'b1;
            next_s.req.wr_data = {s.sh[22:0], din_s};
            next_s.st = serial_cmd_pkg::ST_IDLE; // [R2] [R9]
            next_s.bits = 5'h00;
          end
        end
        serial_cmd_pkg::ST_READ, serial_cmd_pkg::ST_CONT: begin
          next_s.sh = {s.sh[22:0], 1'b0};
          next_s.window = next_window;
          next_s.bits = s.bits + 5'h01;
          if (s.bits == len - 5'h01) begin
            next_s.bits = 5'h00;
            if (s.st == serial_cmd_pkg::ST_READ) begin
              next_s.st = serial_cmd_pkg::ST_IDLE; // [R2] [R10]
            end else begin
              next_s.load = 1'b1; // [R11]
            end
          end
          // Input keeps being watched, byte-aligned to the read word
          if (s.st == serial_cmd_pkg::ST_CONT && s.bits[2:0] == 3'h7 &&
              next_window == serial_cmd_pkg::CMD_STOP) begin // [R13]
            next_s.st = serial_cmd_pkg::ST_IDLE; // [R12]
            next_s.load = 1'b0;
            next_s.bits = 5'h00;
          end
        end
        default: begin
          next_s.st = serial_cmd_pkg::ST_IDLE;
        end
      endcase
      // Resync wins over anything the current transfer wanted
      if (hit) begin // [R4]
        next_s.st = serial_cmd_pkg::ST_IDLE;
        next_s.bits = 5'h00;
        next_s.cmd = serial_cmd_pkg::CMD_RESET_VALUE;
        next_s.load = 1'b0;
        next_s.req.wr_stb = 1'b0;
        next_s.soft_rst = 1'b1;
        next_s.ones = ONES_TOP;
      end
    end
    if (next_s.st != serial_cmd_pkg::ST_READ &&
        next_s.st != serial_cmd_pkg::ST_CONT) begin
      next_s.dout = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= '0; // [R3]
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.dout;
  assign reg_req = s.req;
  assign command = s.cmd;
  assign port_state = s.st;
  assign cont_read_active = (s.st == serial_cmd_pkg::ST_CONT);
  assign soft_reset = s.soft_rst;

  logic cmd_done;
  logic word_end;
  assign cmd_done = rise && !hit && s.st == serial_cmd_pkg::ST_CMD &&
                    s.bits == 5'h06;
  assign word_end = rise && !hit && s.bits == len - 5'h01;

  property p_ones_reset;
    @(posedge mclk) disable iff (!resetn)
      hit |=> soft_reset && port_state == serial_cmd_pkg::ST_IDLE
              ##1 !soft_reset;
  endproperty
  a_ones_reset: assert property (p_ones_reset) // [R4]
    else $error("ones run did not reset the port");

  property p_gate_hold;
    @(posedge mclk) disable iff (!resetn)
      rise && din_s && s.st == serial_cmd_pkg::ST_IDLE |=>
        port_state == serial_cmd_pkg::ST_IDLE;
  endproperty
  a_gate_hold: assert property (p_gate_hold) // [R6]
    else $error("gate bit one advanced the port");

  property p_gate_open;
    @(posedge mclk) disable iff (!resetn)
      rise && !din_s && s.st == serial_cmd_pkg::ST_IDLE |=>
        port_state == serial_cmd_pkg::ST_CMD && s.bits == 5'h00;
  endproperty
  a_gate_open: assert property (p_gate_open) // [R6]
    else $error("gate bit zero did not start the command");

  property p_write_entry;
    @(posedge mclk) disable iff (!resetn)
      cmd_done && kind == serial_cmd_pkg::KIND_WRITE &&
      sel != serial_cmd_pkg::SEL_NONE && sel != serial_cmd_pkg::SEL_STATUS
      |=> port_state == serial_cmd_pkg::ST_WRITE && command == $past(full_cmd);
  endproperty
  a_write_entry: assert property (p_write_entry) // [R9]
    else $error("write command did not enter write transfer");

  property p_write_done;
    @(posedge mclk) disable iff (!resetn)
      word_end && s.st == serial_cmd_pkg::ST_WRITE |=>
        reg_req.wr_stb && port_state == serial_cmd_pkg::ST_IDLE
        ##1 !reg_req.wr_stb;
  endproperty
  a_write_done: assert property (p_write_done) // [R2]
    else $error("single write did not finish into command wait");

  property p_read_load;
    @(posedge mclk) disable iff (!resetn)
      cmd_done && kind == serial_cmd_pkg::KIND_READ &&
      sel != serial_cmd_pkg::SEL_NONE |=>
        port_state == serial_cmd_pkg::ST_READ ##1 reg_req.rd_stb;
  endproperty
  a_read_load: assert property (p_read_load) // [R10]
    else $error("read command did not fetch the register");

  property p_read_done;
    @(posedge mclk) disable iff (!resetn)
      word_end && s.st == serial_cmd_pkg::ST_READ |=>
        port_state == serial_cmd_pkg::ST_IDLE && !dout;
  endproperty
  a_read_done: assert property (p_read_done) // [R2]
    else $error("single read did not return to command wait");

  property p_cont_repeat;
    @(posedge mclk) disable iff (!resetn)
      word_end && s.st == serial_cmd_pkg::ST_CONT &&
      next_window != serial_cmd_pkg::CMD_STOP |=>
        port_state == serial_cmd_pkg::ST_CONT ##1 reg_req.rd_stb;
  endproperty
  a_cont_repeat: assert property (p_cont_repeat) // [R11]
    else $error("continuous read did not restart the word");

  property p_cont_stop;
    @(posedge mclk) disable iff (!resetn)
      rise && !hit && s.st == serial_cmd_pkg::ST_CONT &&
      s.bits[2:0] == 3'h7 && next_window == serial_cmd_pkg::CMD_STOP |=>
        port_state == serial_cmd_pkg::ST_IDLE ##1 !reg_req.rd_stb;
  endproperty
  a_cont_stop: assert property (p_cont_stop) // [R12]
    else $error("stop byte did not end continuous read");

  property p_unused_select;
    @(posedge mclk) disable iff (!resetn)
      cmd_done && sel == serial_cmd_pkg::SEL_NONE |=>
        port_state == serial_cmd_pkg::ST_IDLE &&
        reg_req.select == $past(reg_req.select) && !reg_req.wr_stb
        ##1 !reg_req.rd_stb;
  endproperty
  a_unused_select: assert property (p_unused_select) // [R20]
    else $error("unused select started a transfer");

  property p_status_len;
    @(posedge mclk) disable iff (!resetn)
      reg_req.rd_stb && reg_req.select == serial_cmd_pkg::SEL_STATUS |->
        dout == rd_data[7] && s.sh[23:16] == rd_data[7:0];
  endproperty
  a_status_len: assert property (p_status_len) // [R18]
    else $error("status word not aligned to eight bits");

  c_single_write: cover property (@(posedge mclk) disable iff (!resetn)
    reg_req.wr_stb);
  c_single_read: cover property (@(posedge mclk) disable iff (!resetn)
    word_end && s.st == serial_cmd_pkg::ST_READ);
  c_cont_stop: cover property (@(posedge mclk) disable iff (!resetn)
    s.st == serial_cmd_pkg::ST_CONT ##1
    port_state == serial_cmd_pkg::ST_IDLE);
  c_ones_reset: cover property (@(posedge mclk) disable iff (!resetn)
    soft_reset);

endmodule

// *** dv/serial_host_model.sv ***
// Host side of the serial port: makes the serial clock and data, reads dout.
// Assumes the bench calls xfer; the clock idles high between frames.
`timescale 1ns/1ps
module serial_host_model (
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b1;
    din = 1'b0;
  end

  // Shifts n bits of wd out, collects n bits of dout, both MSB first
  task automatic xfer(input logic [23:0] wd, input int n,
                      output logic [23:0] rd);
    rd = 24'h00_0000;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      din = wd[i];
      #100;
      sclk = 1'b1;
      // Sample early in the high phase: after the last bit the port
      // returns to idle and clears dout a few mclk after the rise
      #40;
      rd[i] = dout;
      #60;
    end
    // Low between frames so no stop byte or ones run forms by accident
    din = 1'b0;
  endtask
endmodule

// *** dv/serial_command_register_decoder_tb.sv ***
// Self-checking bench for the serial command decoder.
// Assumes the host model drives the pins and a small bank here serves rd_data.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  error_cnt++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
  end end
module serial_command_register_decoder_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic word_length_24 = 1'b1;
  logic sclk;
  logic din;
  logic dout;
  logic [23:0] rd_data;
  serial_cmd_pkg::reg_req_s reg_req;
  logic [7:0] command;
  serial_cmd_pkg::port_state_e port_state;
  logic cont_read_active;
  logic soft_reset;
  logic [23:0] bank [8];
  logic [23:0] last_wr;
  logic [23:0] r;
  int error_cnt = 0;
  int n_checks = 0;
  int wr_cnt = 0;
  int soft_cnt = 0;
  int rd_cnt = 0;

  always #12.5 mclk = ~mclk;

  serial_cmd_decoder #(.ONES_LIMIT(8)) serial_cmd_decoder_i (
    .mclk(mclk), .resetn(resetn), .sclk(sclk), .din(din), .dout(dout),
    .word_length_24(word_length_24), .rd_data(rd_data),
    .reg_req(reg_req), .command(command), .port_state(port_state),
    .cont_read_active(cont_read_active), .soft_reset(soft_reset)
  );

  serial_host_model serial_host_model_i (
    .sclk(sclk), .din(din), .dout(dout)
  );

  initial begin
    bank[0] = 24'h00_00C5;
    bank[1] = 24'h12_3456;
    bank[2] = 24'h00_0174;
    bank[3] = 24'h00_2002;
    bank[4] = 24'hDE_AD00;
    bank[5] = 24'h80_1234;
    bank[6] = 24'h59_ABCD;
    bank[7] = 24'h00_0F0F;
  end
  assign rd_data = bank[reg_req.select];

  always @(posedge mclk) begin
    if (reg_req.wr_stb === 1'b1) begin
      wr_cnt++;
      last_wr = reg_req.wr_data;
      bank[reg_req.select] <= reg_req.wr_data;
    end
    if (soft_reset === 1'b1) begin
      soft_cnt++;
    end
    if (reg_req.rd_stb === 1'b1) begin
      rd_cnt++;
    end
  end

  function automatic int len_of(input logic [2:0] s, input logic wl);
    case (s)
      3'h0: return 8;
      3'h1: return wl ? 24 : 16;
      3'h2, 3'h3: return 16;
      default: return 24;
    endcase
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bounded wait for the port to reach state s
  task automatic settle(input serial_cmd_pkg::port_state_e s);
    int i;
    for (i = 0; i < 40 && port_state !== s; i++) begin
      @(negedge mclk);
    end
    `CHK(port_state, s)
    if (port_state !== s) begin
      report_and_stop();
    end
  endtask

  task automatic t_reset();
    `CHK(port_state, serial_cmd_pkg::ST_IDLE)
    `CHK(command, 8'h00)
    `CHK(dout, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_reads();
    logic [2:0] s;
    int n;
    logic [23:0] m;
    for (int k = 0; k < 9; k++) begin
      if (k != 4) begin
        s = (k == 8) ? 3'h1 : 3'(k);
        @(negedge mclk);
        word_length_24 = (k != 8);
        n = len_of(s, word_length_24);
        serial_host_model_i.xfer({16'h0000, 5'h02, s}, 8, r);
        `CHK(command, {5'h02, s})
        serial_host_model_i.xfer(24'h00_0000, n, r);
        m = ~(24'hFF_FFFF << n);
        `CHK(r, bank[s] & m)
        settle(serial_cmd_pkg::ST_IDLE);
      end
    end
    $display("test reads done");
  endtask

  task automatic t_writes();
    // Leading ones hold the port at the gate bit
    serial_host_model_i.xfer(24'h00_0003, 2, r);
    serial_host_model_i.xfer(24'h00_0002, 8, r);
    `CHK(command, 8'h02)
    serial_host_model_i.xfer(24'h00_A55A, 16, r);
    settle(serial_cmd_pkg::ST_IDLE);
    `CHK(wr_cnt, 1)
    `CHK(last_wr, 24'h00_A55A)
    serial_host_model_i.xfer(24'h00_0005, 8, r);
    serial_host_model_i.xfer(24'hF0_0F11, 24, r);
    settle(serial_cmd_pkg::ST_IDLE);
    `CHK(last_wr, 24'hF0_0F11)
    serial_host_model_i.xfer(24'h00_0012, 8, r);
    serial_host_model_i.xfer(24'h00_0000, 16, r);
    `CHK(r, 24'h00_A55A)
    settle(serial_cmd_pkg::ST_IDLE);
    $display("test writes done");
  endtask

  task automatic t_unused();
    serial_host_model_i.xfer(24'h00_0004, 8, r);
    settle(serial_cmd_pkg::ST_IDLE);
    serial_host_model_i.xfer(24'h00_0014, 8, r);
    settle(serial_cmd_pkg::ST_IDLE);
    serial_host_model_i.xfer(24'h00_0000, 8, r);
    settle(serial_cmd_pkg::ST_IDLE);
    `CHK(wr_cnt, 2)
    `CHK(bank[4], 24'hDE_AD00)
    $display("test unused done");
  endtask

  task automatic t_cont();
    int r0;
    @(negedge mclk);
    r0 = rd_cnt;
    word_length_24 = 1'b1;
    serial_host_model_i.xfer(24'h00_0021, 8, r);
    settle(serial_cmd_pkg::ST_CONT);
    for (int w = 0; w < 2; w++) begin
      serial_host_model_i.xfer(24'h00_0000, 24, r);
      `CHK(r, 24'h12_3456)
      `CHK(cont_read_active, 1'b1)
    end
    serial_host_model_i.xfer(24'h00_0030, 8, r);
    settle(serial_cmd_pkg::ST_IDLE);
    `CHK(cont_read_active, 1'b0)
    // One fetch at the command, one after each of the two full words
    `CHK(rd_cnt, r0 + 3)
    $display("test continuous done");
  endtask

  task automatic t_midreset();
    serial_host_model_i.xfer(24'h00_0021, 8, r);
    settle(serial_cmd_pkg::ST_CONT);
    serial_host_model_i.xfer(24'h00_0000, 8, r);
    @(negedge mclk);
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(port_state, serial_cmd_pkg::ST_IDLE)
    `CHK(cont_read_active, 1'b0)
    `CHK(command, 8'h00)
    `CHK(dout, 1'b0)
    resetn = 1'b1;
    // Sync flops need a few mclk before the first serial edge
    repeat (4) @(negedge mclk);
    serial_host_model_i.xfer(24'h00_0010, 8, r);
    serial_host_model_i.xfer(24'h00_0000, 8, r);
    `CHK(r, bank[0] & 24'h00_00FF)
    settle(serial_cmd_pkg::ST_IDLE);
    $display("test mid-run reset done");
  endtask

  task automatic t_ones();
    int s0;
    s0 = soft_cnt;
    serial_host_model_i.xfer(24'h00_0022, 8, r);
    settle(serial_cmd_pkg::ST_CONT);
    // Limit set to 8 in this bench; a run of 8 ones fires the reset
    serial_host_model_i.xfer(24'h00_00FF, 8, r);
    settle(serial_cmd_pkg::ST_IDLE);
    `CHK(soft_cnt, s0 + 1)
    `CHK(command, 8'h00)
    $display("test ones reset done");
  endtask

  initial begin
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset();
    t_reads();
    t_writes();
    t_unused();
    t_cont();
    t_midreset();
    t_ones();
    report_and_stop();
  end

  initial begin
    #1_000_000;
    error_cnt++;
    report_and_stop();
  end
endmodule
